// ===== logic/clk_mode_ctrl.sv
// system clock source selection, speed modes, stop and wait control
//
// How it works
// - middle speed: cpu clock is main input divided by 8; selected after reset
// - high speed: cpu clock is main input divided by 2
// - low speed: cpu clock is sub input divided by 2
// - in low speed, mode control bit 5 stops the main oscillator
// - only permitted mode moves; stop and wait return to the prior mode
// - stop instruction holds cpu clock high and halts both oscillators
// - stop entry presets first timer to ff and second to 01
// - recovery: first timer counts source divided by 16, its underflow clocks second
// - stop entry clears the three-timer mode register except bit 4
// - interrupt restarts oscillators; cpu clock withheld until second timer underflows
// - recovery delay about 1 ms in middle or high speed
// - recovery delay about 0.25 s in low speed
// - wait instruction holds cpu clock high, oscillators left untouched
// - wait ends at once on reset or any interrupt, no settling delay
// - timer and display ticks keep running in wait
// - method pin high cuts main feedback path for rc use; low connects it
// - a timer with latch n divides its source by n plus one
// - after power-on only main runs; sub pins float until selected
//
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "clk_mode_params.svh"
module clk_mode_ctrl (
  input  wire logic                  ref_clk,
  input  wire logic                  reset,
  input  wire logic                  clk_en,
  input  wire clk_mode_pkg::bus_req_t bus_req,
  output logic                 [7:0] rd_data,
  input  wire logic                  main_osc_in,
  input  wire logic                  sub_osc_in,
  input  wire logic                  osc_method_select,
  input  wire logic                  halt_oscillators_instr,
  input  wire logic                  gate_cpu_clock_instr,
  input  wire logic                  ext_irq,
  input  wire logic                  irq_any,
  output logic                       cpu_clk,
  output logic                       main_osc_en,
  output logic                       main_feedback_en,
  output logic                       sub_osc_en,
  output logic                       sub_pin_oe,
  output logic                       periph_tick
);
  clk_mode_pkg::speed_t     cur_spd_ff;
  clk_mode_pkg::speed_t     req_spd_ff;
  clk_mode_pkg::clk_state_t state_ff;
  logic       main_stop_ff;
  logic       sub_sw_ff;
  logic [7:0] t123_ff;
  logic [7:0] t1_latch_ff;
  logic [7:0] t2_latch_ff;
  logic       main_prev_ff;
  logic       sub_prev_ff;
  logic       phi_ff;
  logic [1:0] div_cnt_ff;
  logic [3:0] pre_cnt_ff;
  logic       main_en_ff;
  logic       sub_en_ff;
  logic       tick_ff;
  logic [7:0] rd_data_ff;
  logic       main_rise;
  logic       sub_rise;
  logic       src_rise;
  logic       tmr_src_rise;
  logic       boundary;
  logic       gated;
  logic       stop_entry;
  logic       pre_tick;
  logic       t1_tick;
  logic       t2_tick;
  logic       t1_uf;
  logic       t2_uf;
  logic [7:0] t1_count;
  logic [7:0] t2_count;
  logic [1:0] half_last;
  logic       wr_mode;
  clk_mode_pkg::speed_t wr_spd;
  default clocking cb_ref @(posedge ref_clk); endclocking
  default disable iff (reset);

  ////////////////////////////////////////////////////////////////////////////
  // oscillator edges and divider
  assign main_rise  = main_osc_in && !main_prev_ff;
  assign sub_rise   = sub_osc_in && !sub_prev_ff;
  assign src_rise   = (cur_spd_ff == clk_mode_pkg::spd_low) ? sub_rise : main_rise;
  assign half_last  = (cur_spd_ff == clk_mode_pkg::spd_middle) ? `MID_HALF_LAST : `HS_HALF_LAST;
  assign boundary   = src_rise && (div_cnt_ff == half_last);
  assign gated      = (state_ff != clk_mode_pkg::st_run);
  assign stop_entry = clk_en && (state_ff == clk_mode_pkg::st_run) && halt_oscillators_instr;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      main_prev_ff <= 1'b0;
      sub_prev_ff  <= 1'b0;
    end else if (clk_en) begin
      main_prev_ff <= main_osc_in;
      sub_prev_ff  <= sub_osc_in;
    end
  end

  // half periods are whole source periods, so no pulse is shorter than one
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      div_cnt_ff <= 2'h0;
      phi_ff     <= 1'b1;
    end else if (clk_en && src_rise) begin
      if (boundary) begin
        div_cnt_ff <= 2'h0;
        if (!phi_ff) begin
          phi_ff <= 1'b1;
        end else if (!gated) begin
          phi_ff <= 1'b0;
        end
      end else begin
        div_cnt_ff <= div_cnt_ff + 2'h1;
      end
    end
  end

  // new source or divider only takes over at the end of a high half
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cur_spd_ff <= clk_mode_pkg::spd_middle;
    end else if (clk_en && boundary && phi_ff) begin
      cur_spd_ff <= req_spd_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register writes
  assign wr_mode = clk_en && bus_req.wr && (bus_req.addr == `ADDR_MODE_CTRL);
  assign wr_spd  = clk_mode_pkg::speed_t'(bus_req.wdata[1:0]);

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      req_spd_ff   <= clk_mode_pkg::spd_middle;
      main_stop_ff <= 1'b0;
      sub_sw_ff    <= 1'b0;
    end else if (wr_mode) begin
      sub_sw_ff <= bus_req.wdata[`MODE_SUB_SW_BIT];
      // low speed needs the sub port; middle/high need a running main
      if (bus_req.wdata[1:0] != 2'h3) begin
        if ((wr_spd == clk_mode_pkg::spd_low) ? bus_req.wdata[`MODE_SUB_SW_BIT] : !main_stop_ff) begin
          req_spd_ff <= wr_spd;
        end
      end
      if (req_spd_ff == clk_mode_pkg::spd_low && cur_spd_ff == req_spd_ff && wr_spd == req_spd_ff) begin
        main_stop_ff <= bus_req.wdata[`MODE_MAIN_STOP_BIT];
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      t123_ff <= 8'h00;
    end else if (stop_entry) begin
      t123_ff <= t123_ff & `T123_KEEP_MASK;
    end else if (clk_en && bus_req.wr && bus_req.addr == `ADDR_T123_MODE) begin
      t123_ff <= bus_req.wdata;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      t1_latch_ff <= `T1_RESET_VAL;
      t2_latch_ff <= `T2_RESET_VAL;
    end else if (stop_entry) begin
      t1_latch_ff <= `T1_STOP_PRESET;
      t2_latch_ff <= `T2_STOP_PRESET;
    end else if (clk_en && bus_req.wr) begin
      if (bus_req.addr == `ADDR_T1_LATCH) begin
        t1_latch_ff <= bus_req.wdata;
      end else if (bus_req.addr == `ADDR_T2_LATCH) begin
        t2_latch_ff <= bus_req.wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stop and wait sequencing
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_ff <= clk_mode_pkg::st_run;
    end else if (clk_en) begin
      case (state_ff)
        clk_mode_pkg::st_run: begin
          if (halt_oscillators_instr) begin
            state_ff <= clk_mode_pkg::st_stop_halted;
          end else if (gate_cpu_clock_instr) begin
            state_ff <= clk_mode_pkg::st_wait;
          end
        end
        clk_mode_pkg::st_stop_halted: begin
          if (ext_irq) begin
            state_ff <= clk_mode_pkg::st_stop_settle;
          end
        end
        clk_mode_pkg::st_stop_settle: begin
          if (t2_uf) begin
            state_ff <= clk_mode_pkg::st_run;
          end
        end
        clk_mode_pkg::st_wait: begin
          if (irq_any) begin
            state_ff <= clk_mode_pkg::st_run;
          end
        end
        default: state_ff <= clk_mode_pkg::st_run;
      endcase
    end
  end

  // oscillators halt only once the clock sits high, else it could freeze low
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      main_en_ff <= 1'b1;
      sub_en_ff  <= 1'b0;
    end else if (clk_en) begin
      if (state_ff == clk_mode_pkg::st_stop_halted && phi_ff) begin
        main_en_ff <= 1'b0;
        sub_en_ff  <= 1'b0;
      end else if (state_ff != clk_mode_pkg::st_wait) begin
        main_en_ff <= !main_stop_ff;
        sub_en_ff  <= sub_sw_ff;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // prescaler and cascaded timers
  assign tmr_src_rise = (req_spd_ff == clk_mode_pkg::spd_low) ? sub_rise : main_rise;
  assign pre_tick     = tmr_src_rise && (pre_cnt_ff == `PRESCALE_LAST);
  assign t1_tick      = pre_tick && !t123_ff[`T123_T1_STOP_BIT];
  assign t2_tick      = t1_uf && !t123_ff[`T123_T2_STOP_BIT];

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pre_cnt_ff <= 4'h0;
      tick_ff    <= 1'b0;
    end else if (clk_en) begin
      if (stop_entry) begin
        pre_cnt_ff <= 4'h0;
      end else if (tmr_src_rise) begin
        pre_cnt_ff <= pre_cnt_ff + 4'h1;
      end
      tick_ff <= pre_tick;
    end
  end

  stab_timer #(.RESET_VAL(`T1_RESET_VAL)) u_timer1 (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .clk_en    (clk_en),
    .load      (stop_entry),
    .tick      (t1_tick),
    .latch_val (stop_entry ? `T1_STOP_PRESET : t1_latch_ff),
    .count     (t1_count),
    .underflow (t1_uf)
  );

  stab_timer #(.RESET_VAL(`T2_RESET_VAL)) u_timer2 (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .clk_en    (clk_en),
    .load      (stop_entry),
    .tick      (t2_tick),
    .latch_val (stop_entry ? `T2_STOP_PRESET : t2_latch_ff),
    .count     (t2_count),
    .underflow (t2_uf)
  );

  ////////////////////////////////////////////////////////////////////////////
  // register reads, one cycle later
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rd_data_ff <= 8'h00;
    end else if (clk_en) begin
      if (!bus_req.rd) begin
        rd_data_ff <= 8'h00;
      end else if (bus_req.addr == `ADDR_MODE_CTRL) begin
        rd_data_ff <= {2'h0, main_stop_ff, sub_sw_ff, 2'h0, req_spd_ff};
      end else if (bus_req.addr == `ADDR_T123_MODE) begin
        rd_data_ff <= t123_ff;
      end else if (bus_req.addr == `ADDR_T1_LATCH) begin
        rd_data_ff <= t1_latch_ff;
      end else if (bus_req.addr == `ADDR_T2_LATCH) begin
        rd_data_ff <= t2_latch_ff;
      end else if (bus_req.addr == `ADDR_STATUS) begin
        rd_data_ff <= {sub_en_ff, main_en_ff, phi_ff, 1'b0, state_ff, cur_spd_ff};
      end else if (bus_req.addr == `ADDR_T1_COUNT) begin
        rd_data_ff <= t1_count;
      end else if (bus_req.addr == `ADDR_T2_COUNT) begin
        rd_data_ff <= t2_count;
      end else begin
        rd_data_ff <= 8'h00;
      end
    end
  end

  assign rd_data          = rd_data_ff;
  assign cpu_clk          = phi_ff;
  assign main_osc_en      = main_en_ff;
  assign sub_osc_en       = sub_en_ff;
  assign sub_pin_oe       = sub_en_ff;
  assign main_feedback_en = !osc_method_select;
  assign periph_tick      = tick_ff;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  sequence s_stop_entry;
    clk_en && state_ff == clk_mode_pkg::st_run && halt_oscillators_instr;
  endsequence
  sequence s_settle_done;
    clk_en && state_ff == clk_mode_pkg::st_stop_settle && t2_uf;
  endsequence
  property p_mid_hold;
    clk_en && cur_spd_ff == clk_mode_pkg::spd_middle && src_rise && div_cnt_ff != 2'h3 |=> $stable(phi_ff);
  endproperty
  a_mid_hold: assert property (p_mid_hold) else $error("middle divider toggled early");
  property p_high_toggle;
    clk_en && !gated && cur_spd_ff == clk_mode_pkg::spd_high && main_rise |=> phi_ff != $past(phi_ff);
  endproperty
  a_high_toggle: assert property (p_high_toggle) else $error("high speed clock missed a toggle");
  property p_low_toggle;
    clk_en && !gated && cur_spd_ff == clk_mode_pkg::spd_low && sub_rise |=> phi_ff != $past(phi_ff);
  endproperty
  a_low_toggle: assert property (p_low_toggle) else $error("low speed clock missed a toggle");
  property p_main_stop_low;
    main_stop_ff |-> req_spd_ff == clk_mode_pkg::spd_low;
  endproperty
  a_main_stop_low: assert property (p_main_stop_low) else $error("main stopped outside low speed");
  property p_stop_halt;
    clk_en && state_ff == clk_mode_pkg::st_stop_halted && phi_ff |=> !main_en_ff && !sub_en_ff && phi_ff;
  endproperty
  a_stop_halt: assert property (p_stop_halt) else $error("oscillators still running in stop");
  property p_stop_preset;
    s_stop_entry |=> t1_count == 8'hff && t2_count == 8'h01;
  endproperty
  a_stop_preset: assert property (p_stop_preset) else $error("timers not preset on stop");
  property p_t123_clear;
    s_stop_entry |=> t123_ff == ($past(t123_ff) & 8'h10);
  endproperty
  a_t123_clear: assert property (p_t123_clear) else $error("timer mode register not cleared on stop");
  property p_withhold;
    state_ff == clk_mode_pkg::st_stop_settle |-> phi_ff;
  endproperty
  a_withhold: assert property (p_withhold) else $error("cpu clock ran before recovery ended");
  property p_release;
    s_settle_done |=> state_ff == clk_mode_pkg::st_run && cur_spd_ff == $past(cur_spd_ff);
  endproperty
  a_release: assert property (p_release) else $error("stop recovery did not return to prior mode");
  property p_wait_osc;
    state_ff == clk_mode_pkg::st_wait |=> $stable(main_en_ff) && $stable(sub_en_ff);
  endproperty
  a_wait_osc: assert property (p_wait_osc) else $error("oscillators changed in wait");
  property p_wait_resume;
    clk_en && state_ff == clk_mode_pkg::st_wait && irq_any |=> state_ff == clk_mode_pkg::st_run;
  endproperty
  a_wait_resume: assert property (p_wait_resume) else $error("wait did not end on interrupt");
  property p_feedback;
    main_feedback_en != osc_method_select;
  endproperty
  a_feedback: assert property (p_feedback) else $error("feedback path does not follow method pin");
endmodule : clk_mode_ctrl

// ===== logic/clk_mode_params.svh
// offsets, field positions, reset values and counts of the system clock mode control block
`ifndef CLK_MODE_PARAMS_SVH
`define CLK_MODE_PARAMS_SVH
`define ADDR_MODE_CTRL    3'h0
`define ADDR_T123_MODE    3'h1
`define ADDR_T1_LATCH     3'h2
`define ADDR_T2_LATCH     3'h3
`define ADDR_STATUS       3'h4
`define ADDR_T1_COUNT     3'h5
`define ADDR_T2_COUNT     3'h6
`define MODE_SUB_SW_BIT   4
`define MODE_MAIN_STOP_BIT 5
`define T123_KEEP_MASK    8'h10
`define T123_T1_STOP_BIT  0
`define T123_T2_STOP_BIT  1
`define T1_STOP_PRESET    8'hff
`define T2_STOP_PRESET    8'h01
`define T1_RESET_VAL      8'hff
`define T2_RESET_VAL      8'h01
`define PRESCALE_LAST     4'hf
`define MID_HALF_LAST     2'h3
`define HS_HALF_LAST      2'h0
`endif

// ===== logic/clk_mode_pkg.sv
// types shared by the system clock mode control block
package clk_mode_pkg;
  typedef enum logic [1:0] {spd_middle, spd_high, spd_low} speed_t;
  typedef enum logic [1:0] {st_run, st_stop_halted, st_stop_settle, st_wait} clk_state_t;
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_t;
endpackage : clk_mode_pkg

// ===== logic/stab_timer.sv
// 8-bit reloadable down counter used for general timing and stop recovery
`timescale 1ns/1ps
module stab_timer #(
  parameter logic [7:0] RESET_VAL = 8'h00
) (
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic       clk_en,
  input  wire logic       load,
  input  wire logic       tick,
  input  wire logic [7:0] latch_val,
  output logic      [7:0] count,
  output logic            underflow
);
  logic [7:0] count_ff;

  // count n..0 then reload: divide by n plus one
  assign underflow = tick && !load && (count_ff == 8'h00);

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      count_ff <= RESET_VAL;
    end else if (clk_en) begin
      if (load || underflow) begin
        count_ff <= latch_val;
      end else if (tick) begin
        count_ff <= count_ff - 8'h01;
      end
    end
  end

  // reset value is fixed per instance so the async branch stays constant
  assign count = count_ff;
endmodule : stab_timer

// ===== bench/osc_model.sv
// oscillator pair feeding the clock mode control block
`timescale 1ns/1ps
module osc_model #(
  parameter int MAIN_HALF = 2,
  parameter int SUB_HALF  = 7
) (
  input  wire logic ref_clk,
  input  wire logic reset,
  input  wire logic main_en,
  input  wire logic sub_en,
  output logic      main_out,
  output logic      sub_out
);
  // main period 4 cycles, sub period 14: main stays above three times sub
  int main_cnt;
  int sub_cnt;
  ////////////////////////////////////////////////////////////////
  // a halted oscillator sits low and restarts from a fresh half period
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      main_cnt <= 0;
      main_out <= 1'b0;
    end else if (!main_en) begin
      main_cnt <= 0;
      main_out <= 1'b0;
    end else if (main_cnt == MAIN_HALF - 1) begin
      main_cnt <= 0;
      main_out <= !main_out;
    end else begin
      main_cnt <= main_cnt + 1;
    end
  end
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sub_cnt <= 0;
      sub_out <= 1'b0;
    end else if (!sub_en) begin
      sub_cnt <= 0;
      sub_out <= 1'b0;
    end else if (sub_cnt == SUB_HALF - 1) begin
      sub_cnt <= 0;
      sub_out <= !sub_out;
    end else begin
      sub_cnt <= sub_cnt + 1;
    end
  end
endmodule : osc_model

// ===== bench/tb_system_clock_mode_control.sv
// self-checking bench of the clock mode control block
`timescale 1ns/1ps
`include "clk_mode_params.svh"
`define CHECK(nm, got, exp) begin tests_run++; if ((got) !== (exp)) begin \
  $display("unexpected %s exp=%0h got=%0h", nm, exp, got); n_errors++; end end
module tb_system_clock_mode_control;
  localparam int MAIN_HALF = 2;
  localparam int SUB_HALF  = 7;
  logic                   ref_clk;
  logic                   reset;
  logic                   clk_en;
  clk_mode_pkg::bus_req_t bus_req;
  logic [7:0]             rd_data;
  logic                   main_osc_in;
  logic                   sub_osc_in;
  logic                   osc_method_select;
  logic                   halt_instr;
  logic                   gate_instr;
  logic                   ext_irq;
  logic                   irq_any;
  logic                   cpu_clk;
  logic                   main_osc_en;
  logic                   main_feedback_en;
  logic                   sub_osc_en;
  logic                   sub_pin_oe;
  logic                   periph_tick;
  logic [7:0]             d;
  logic [7:0]             v;
  int                     n_errors;
  int                     tests_run;
  int                     cycles;
  int                     p;
  int                     n;
  int                     t0;

  clk_mode_ctrl u_dut (
    .ref_clk(ref_clk), .reset(reset), .clk_en(clk_en), .bus_req(bus_req), .rd_data(rd_data),
    .main_osc_in(main_osc_in), .sub_osc_in(sub_osc_in), .osc_method_select(osc_method_select),
    .halt_oscillators_instr(halt_instr), .gate_cpu_clock_instr(gate_instr), .ext_irq(ext_irq),
    .irq_any(irq_any), .cpu_clk(cpu_clk), .main_osc_en(main_osc_en), .main_feedback_en(main_feedback_en),
    .sub_osc_en(sub_osc_en), .sub_pin_oe(sub_pin_oe), .periph_tick(periph_tick)
  );
  osc_model #(.MAIN_HALF(MAIN_HALF), .SUB_HALF(SUB_HALF)) u_osc (
    .ref_clk(ref_clk), .reset(reset), .main_en(main_osc_en), .sub_en(sub_osc_en),
    .main_out(main_osc_in), .sub_out(sub_osc_in)
  );

  always #50 ref_clk = !ref_clk;
  ////////////////////////////////////////////////////////////////
  task automatic final_report();
    if (n_errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report
  // stop recovery runs about 33k cycles; everything else is short
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 50000) begin
      n_errors++;
      final_report();
    end
  end
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] wd);
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: wd, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus_req.wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [2:0] a, output logic [7:0] rd);
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus_req.rd <= 1'b0;
    #1 rd = rd_data;
  endtask : rd_reg
  // sel bits: halt, gate, ext_irq, irq_any
  task automatic pulse(input logic [3:0] sel);
    @(posedge ref_clk);
    {halt_instr, gate_instr, ext_irq, irq_any} <= sel;
    @(posedge ref_clk);
    {halt_instr, gate_instr, ext_irq, irq_any} <= 4'h0;
  endtask : pulse
  // waits for a rising cpu_clk, then counts one full period
  task automatic period(output int pr);
    int k;
    k = 0;
    pr = 0;
    while (cpu_clk !== 1'b0 && k < 500) begin @(posedge ref_clk); #1 k++; end
    while (cpu_clk !== 1'b1 && k < 500) begin @(posedge ref_clk); #1 k++; end
    while (cpu_clk !== 1'b0 && pr < 500) begin @(posedge ref_clk); #1 pr++; end
    while (cpu_clk !== 1'b1 && pr < 500) begin @(posedge ref_clk); #1 pr++; end
  endtask : period
  function automatic int exp_period(input logic [1:0] sp);
    case (sp)
      2'h1:    return 2 * 2 * MAIN_HALF;
      2'h2:    return 2 * 2 * SUB_HALF;
      default: return 8 * 2 * MAIN_HALF;
    endcase
  endfunction : exp_period
  // speed change lands at a half-period boundary, so the second period is the clean one
  task automatic chk_speed(input logic [1:0] sp);
    period(p);
    period(p);
    `CHECK("cpu_clk period", p, exp_period(sp))
    rd_reg(`ADDR_STATUS, v);
    `CHECK("status speed", v[1:0], sp)
  endtask : chk_speed

  ////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    reset = 1'b1;
    clk_en = 1'b1;
    bus_req = '0;
    osc_method_select = 1'b0;
    halt_instr = 1'b0;
    gate_instr = 1'b0;
    ext_irq = 1'b0;
    irq_any = 1'b0;
    n_errors = 0;
    tests_run = 0;
    cycles = 0;
    void'($urandom(32'h1b17));
    repeat (10) @(posedge ref_clk);
    `CHECK("cpu_clk in reset", cpu_clk, 1'b1)
    `CHECK("main_osc_en in reset", main_osc_en, 1'b1)
    `CHECK("sub_pin_oe in reset", sub_pin_oe, 1'b0)
    reset <= 1'b0;
    rd_reg(`ADDR_STATUS, v);
    `CHECK("status after reset", v, 8'h60)
    rd_reg(`ADDR_T2_LATCH, v);
    `CHECK("t2 latch reset", v, `T2_RESET_VAL)
    rd_reg(`ADDR_T1_COUNT, v);
    `CHECK("t1 count reset", v, `T1_RESET_VAL)
    chk_speed(2'h0);
    // clock enable low must freeze the divider longer than a half period
    @(posedge ref_clk);
    clk_en <= 1'b0;
    @(posedge ref_clk);
    #1 v[0] = cpu_clk;
    n = 0;
    repeat (40) begin
      @(posedge ref_clk);
      #1 if (cpu_clk !== v[0]) n++;
    end
    @(posedge ref_clk);
    clk_en <= 1'b1;
    `CHECK("cpu_clk frozen by clk_en", n, 0)
    for (int i = 0; i < 6; i++) begin
      d = 8'($urandom);
      wr_reg(`ADDR_T1_LATCH, d);
      rd_reg(`ADDR_T1_LATCH, v);
      `CHECK("t1 latch", v, d)
      wr_reg(3'h7, 8'($urandom));
      rd_reg(3'h7, v);
      `CHECK("unmapped read", v, 8'h00)
      @(posedge ref_clk);
      osc_method_select <= d[0];
      @(posedge ref_clk);
      #1 `CHECK("main_feedback_en", main_feedback_en, !d[0])
    end
    wr_reg(`ADDR_MODE_CTRL, 8'h01);
    chk_speed(2'h1);
    wr_reg(`ADDR_MODE_CTRL, 8'h02);
    chk_speed(2'h1);
    wr_reg(`ADDR_MODE_CTRL, 8'h00);
    chk_speed(2'h0);
    wr_reg(`ADDR_MODE_CTRL, 8'h10);
    repeat (200) @(posedge ref_clk);
    `CHECK("sub_pin_oe", sub_pin_oe, 1'b1)
    wr_reg(`ADDR_MODE_CTRL, 8'h12);
    chk_speed(2'h2);
    wr_reg(`ADDR_MODE_CTRL, 8'h32);
    repeat (4) @(posedge ref_clk);
    `CHECK("main_osc_en low speed stop", main_osc_en, 1'b0)
    wr_reg(`ADDR_MODE_CTRL, 8'h11);
    chk_speed(2'h2);
    wr_reg(`ADDR_MODE_CTRL, 8'h12);
    repeat (200) @(posedge ref_clk);
    `CHECK("main_osc_en restart", main_osc_en, 1'b1)
    wr_reg(`ADDR_MODE_CTRL, 8'h10);
    chk_speed(2'h0);
    pulse(4'h4);
    repeat (40) @(posedge ref_clk);
    n = 0;
    p = 0;
    repeat (200) begin
      @(posedge ref_clk);
      #1 if (cpu_clk !== 1'b1) p++;
      if (periph_tick === 1'b1) n++;
    end
    `CHECK("cpu_clk low in wait", p, 0)
    `CHECK("ticks in wait", n >= 2, 1'b1)
    `CHECK("oscillators in wait", {main_osc_en, sub_osc_en}, 2'h3)
    rd_reg(`ADDR_STATUS, v);
    `CHECK("status wait", v[3:0], 4'hc)
    pulse(4'h1);
    p = 0;
    while (cpu_clk !== 1'b0 && p < 300) begin @(posedge ref_clk); #1 p++; end
    `CHECK("wait release prompt", p < 2 * 8 * MAIN_HALF + 4, 1'b1)
    chk_speed(2'h0);
    wr_reg(`ADDR_T123_MODE, 8'h13);
    pulse(4'h8);
    rd_reg(`ADDR_STATUS, v);
    `CHECK("status stop", v[3:2], 2'h1)
    rd_reg(`ADDR_T1_COUNT, v);
    `CHECK("t1 preset", v, `T1_STOP_PRESET)
    rd_reg(`ADDR_T2_COUNT, v);
    `CHECK("t2 preset", v, `T2_STOP_PRESET)
    rd_reg(`ADDR_T123_MODE, v);
    `CHECK("t123 mode on stop", v, 8'h10)
    repeat (100) @(posedge ref_clk);
    `CHECK("oscillators in stop", {main_osc_en, sub_osc_en, cpu_clk}, 3'h1)
    pulse(4'h2);
    t0 = cycles;
    repeat (4) @(posedge ref_clk);
    `CHECK("main_osc_en restart", main_osc_en, 1'b1)
    rd_reg(`ADDR_STATUS, v);
    `CHECK("status settle", v[3:2], 2'h2)
    while (cpu_clk !== 1'b0 && cycles - t0 < 40000) begin @(posedge ref_clk); #1; end
    n = cycles - t0;
    `CHECK("release delay low", n >= 16 * 256 * 2 * 2 * MAIN_HALF - 64, 1'b1)
    `CHECK("release delay high", n <= 16 * 256 * 2 * 2 * MAIN_HALF + 200, 1'b1)
    rd_reg(`ADDR_STATUS, v);
    `CHECK("status after stop", v[3:0], 4'h0)
    final_report();
  end
endmodule : tb_system_clock_mode_control
